// ---- include/lkt_pkg.sv ----
// Constants and types for the serial link error tracker
`default_nettype none
package lkt_pkg;
  localparam logic [15:0] LKT_ERR_ADDR   = 16'h0219;
  localparam int          LKT_ERR_W      = 7;
  localparam logic [6:0]  LKT_ERR_RST    = 7'h00;
  localparam int          LKT_B_RWDATA   = 6;
  localparam int          LKT_B_TMO      = 5;
  localparam int          LKT_B_CSUM     = 4;
  localparam int          LKT_B_LENPAR   = 3;
  localparam int          LKT_B_RWPAR    = 2;
  localparam int          LKT_B_HDR      = 1;
  localparam int          LKT_B_FRAME    = 0;
  localparam logic [6:0]  LKT_FATAL_MASK = 7'h1f;
  localparam int          LKT_RW_DIR_BIT = 0;
  localparam logic [7:0]  LKT_RW_RSV     = 8'h3e;
  localparam logic [7:0]  LKT_LEN_ONE    = 8'h01;
  localparam int          LKT_GAP_FIELDS = 3;
  localparam int          LKT_REC_FIELDS = 4;
  localparam int          LKT_FIELD_CYC  = 1000;
  localparam int          LKT_TMR_W      = 16;

  typedef enum logic [1:0] {
    LKT_STANDBY,
    LKT_COMM,
    LKT_ERROR
  } lkt_mode_t;

  typedef enum logic [2:0] {
    LKT_F_HDR,
    LKT_F_RW,
    LKT_F_LEN,
    LKT_F_DATA,
    LKT_F_CSUM
  } lkt_fkind_t;

  typedef struct packed {
    logic       valid;
    lkt_fkind_t kind;
    logic [7:0] data;
    logic       par_err;
    logic       stop_err;
    logic       hdr_err;
    logic       csum_err;
    logic       last;
  } lkt_field_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  len;
  } lkt_read_t;

  typedef struct packed {
    logic [LKT_TMR_W-1:0] cnt;
    logic                 hit;
  } lkt_tmr_t;

  typedef struct packed {
    lkt_mode_t  mode;
    logic [6:0] flags;
    logic       wr;
    logic       rw_bad;
    logic       commit;
    logic       nullify;
    logic       rd_go;
  } lkt_state_t;

  function automatic logic lkt_clears(input lkt_read_t rd);
    lkt_clears = rd.valid && rd.addr == LKT_ERR_ADDR && rd.len == LKT_LEN_ONE;
  endfunction : lkt_clears
endpackage : lkt_pkg
`default_nettype wire

// ---- logic/lkt_gap_timer.sv ----
// Idle timer that flags once a count runs past its limit
`timescale 1ns/10ps
`default_nettype none
module lkt_gap_timer #(
  parameter int unsigned LIMIT = 3000
) (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_run,
  input  wire logic i_clr,
  output logic      o_hit
);
  localparam logic [lkt_pkg::LKT_TMR_W-1:0] LIM =
    LIMIT[lkt_pkg::LKT_TMR_W-1:0];
  lkt_pkg::lkt_tmr_t s_r;
  lkt_pkg::lkt_tmr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (i_clr || !i_run) begin
      s_nxt.cnt = '0;
      s_nxt.hit = 1'b0;
    end else begin
      // Saturate so a long idle line never wraps back to zero
      if (s_r.cnt <= LIM) begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
      s_nxt.hit = (s_r.cnt >= LIM);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_hit = s_r.hit;
endmodule : lkt_gap_timer
`default_nettype wire

// ---- logic/lkt_err_decode.sv ----
// Maps one received field to the error bits it raises
`timescale 1ns/10ps
`default_nettype none
module lkt_err_decode (
  input  wire lkt_pkg::lkt_field_t i_fld,
  input  wire logic                i_wr,
  output logic [6:0]               o_set,
  output logic                     o_fatal
);
  always_comb begin
    o_set = '0;
    if (i_fld.valid) begin
      o_set[lkt_pkg::LKT_B_RWDATA] = i_fld.kind == lkt_pkg::LKT_F_RW &&
        !i_fld.par_err && |(i_fld.data & lkt_pkg::LKT_RW_RSV);
      o_set[lkt_pkg::LKT_B_CSUM] = i_fld.kind == lkt_pkg::LKT_F_CSUM &&
        i_wr && i_fld.csum_err;
      o_set[lkt_pkg::LKT_B_LENPAR] = i_fld.kind == lkt_pkg::LKT_F_LEN &&
        i_fld.par_err;
      o_set[lkt_pkg::LKT_B_RWPAR] = i_fld.kind == lkt_pkg::LKT_F_RW &&
        i_fld.par_err;
      o_set[lkt_pkg::LKT_B_HDR] = i_fld.kind == lkt_pkg::LKT_F_HDR &&
        i_fld.hdr_err;
      o_set[lkt_pkg::LKT_B_FRAME] = i_fld.stop_err;
    end
    o_fatal = |(o_set & lkt_pkg::LKT_FATAL_MASK);
  end
endmodule : lkt_err_decode
`default_nettype wire

// ---- logic/lkt_link_err_tracker.sv ----
// Error flags, mode control and recovery for the serial link
`timescale 1ns/10ps
`default_nettype none
module lkt_link_err_tracker #(
  parameter int unsigned FIELD_CYC = lkt_pkg::LKT_FIELD_CYC
) (
  input  wire logic                i_mclk,
  input  wire logic                i_rst_n,
  input  wire logic                i_link,
  input  wire lkt_pkg::lkt_field_t i_fld,
  input  wire lkt_pkg::lkt_read_t  i_rd,
  output logic [6:0]               o_err_flags,
  output lkt_pkg::lkt_mode_t       o_mode,
  output logic                     o_commit,
  output logic                     o_nullify,
  output logic                     o_rd_go
);
  localparam int unsigned GAP_LIM = lkt_pkg::LKT_GAP_FIELDS * FIELD_CYC;
  localparam int unsigned REC_LIM = lkt_pkg::LKT_REC_FIELDS * FIELD_CYC;

  lkt_pkg::lkt_state_t s_r;
  lkt_pkg::lkt_state_t s_nxt;
  logic [6:0]          dset;
  logic                dfatal;
  logic                gap_hit;
  logic                rec_hit;
  logic                in_comm;
  logic                in_err;

  assign in_comm = (s_r.mode == lkt_pkg::LKT_COMM);
  assign in_err  = (s_r.mode == lkt_pkg::LKT_ERROR);

  lkt_err_decode u_dec (
    .i_fld   (i_fld),
    .i_wr    (s_r.wr),
    .o_set   (dset),
    .o_fatal (dfatal)
  );

  // Gap between fields only counts while a transfer is open
  lkt_gap_timer #(.LIMIT(GAP_LIM)) u_gap (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_run   (in_comm),
    .i_clr   (i_fld.valid),
    .o_hit   (gap_hit)
  );

  // Any low level restarts the recovery wait
  lkt_gap_timer #(.LIMIT(REC_LIM)) u_rec (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_run   (in_err),
    .i_clr   (!i_link),
    .o_hit   (rec_hit)
  );

  always_comb begin
    logic [6:0] set;
    logic       clr;
    set = '0;
    clr = lkt_pkg::lkt_clears(i_rd);
    s_nxt = s_r;
    s_nxt.commit  = 1'b0;
    s_nxt.nullify = 1'b0;
    s_nxt.rd_go   = 1'b0;
    case (s_r.mode)
      lkt_pkg::LKT_STANDBY: begin
        if (i_fld.valid) begin
          set = dset;
          if (dfatal) begin
            s_nxt.mode    = lkt_pkg::LKT_ERROR;
            s_nxt.nullify = 1'b1;
          end else if (i_fld.kind == lkt_pkg::LKT_F_HDR && !i_fld.last) begin
            s_nxt.mode   = lkt_pkg::LKT_COMM;
            s_nxt.wr     = 1'b0;
            s_nxt.rw_bad = 1'b0;
          end
        end
      end
      lkt_pkg::LKT_COMM: begin
        if (gap_hit) begin
          // Earlier committed portions stay; only the open one is lost
          set[lkt_pkg::LKT_B_TMO] = 1'b1;
          s_nxt.mode = lkt_pkg::LKT_STANDBY;
          s_nxt.wr   = 1'b0;
        end else if (i_fld.valid) begin
          set = dset;
          if (dfatal) begin
            s_nxt.mode    = lkt_pkg::LKT_ERROR;
            s_nxt.nullify = 1'b1;
            s_nxt.wr      = 1'b0;
          end else begin
            case (i_fld.kind)
              lkt_pkg::LKT_F_RW: begin
                if (dset[lkt_pkg::LKT_B_RWDATA]) begin
                  s_nxt.rw_bad = 1'b1;
                  s_nxt.wr     = 1'b0;
                end else begin
                  s_nxt.wr    = i_fld.data[lkt_pkg::LKT_RW_DIR_BIT];
                  s_nxt.rd_go = !i_fld.data[lkt_pkg::LKT_RW_DIR_BIT];
                end
              end
              lkt_pkg::LKT_F_CSUM: begin
                s_nxt.commit = s_r.wr && !s_r.rw_bad;
              end
              default: begin
              end
            endcase
            if (i_fld.last) begin
              s_nxt.mode = lkt_pkg::LKT_STANDBY;
              s_nxt.wr   = 1'b0;
            end
          end
        end
      end
      lkt_pkg::LKT_ERROR: begin
        // Fields are dropped unseen until the line idles high
        if (rec_hit) begin
          s_nxt.mode = lkt_pkg::LKT_STANDBY;
        end
      end
      default: begin
        s_nxt.mode = lkt_pkg::LKT_STANDBY;
      end
    endcase
    // A new error in the clearing cycle survives the clear
    s_nxt.flags = (clr ? 7'h00 : s_r.flags) | set;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      s_r       <= '0;
      s_r.mode  <= lkt_pkg::LKT_STANDBY;
      s_r.flags <= lkt_pkg::LKT_ERR_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_err_flags = s_r.flags;
  assign o_mode      = s_r.mode;
  assign o_commit    = s_r.commit;
  assign o_nullify   = s_r.nullify;
  assign o_rd_go     = s_r.rd_go;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  property p_sticky;
    s_r.flags != 7'h00 && !lkt_pkg::lkt_clears(i_rd)
      |=> ($past(s_r.flags) & ~s_r.flags) == 7'h00;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("error bit fell without a read");

  // Only a quiet cycle has no competing set, so the clear must show fully
  property p_clear;
    lkt_pkg::lkt_clears(i_rd) && !i_fld.valid && !gap_hit
      |=> s_r.flags == 7'h00;
  endproperty
  a_clear: assert property (p_clear)
    else $error("single byte read did not clear flags");

  property p_multi;
    i_rd.valid && i_rd.len != lkt_pkg::LKT_LEN_ONE
      |=> ($past(s_r.flags) & ~s_r.flags) == 7'h00;
  endproperty
  a_multi: assert property (p_multi)
    else $error("multi byte read cleared flags");

  property p_rwdata;
    in_comm && !gap_hit && i_fld.valid && i_fld.kind == lkt_pkg::LKT_F_RW
      && !i_fld.par_err && !i_fld.stop_err && i_fld.data[5:1] != 5'h00
      && !i_fld.last
      |=> s_r.flags[6] && in_comm && !s_r.rd_go ##1 !s_r.commit;
  endproperty
  a_rwdata: assert property (p_rwdata)
    else $error("rw data error handled wrong");

  property p_tmo;
    in_comm && gap_hit
      |=> s_r.flags[5] && s_r.mode == lkt_pkg::LKT_STANDBY && !s_r.nullify;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("timeout did not end transfer");

  property p_csum;
    in_comm && !gap_hit && i_fld.valid && i_fld.kind == lkt_pkg::LKT_F_CSUM
      && i_fld.csum_err && s_r.wr
      |=> s_r.flags[4] && in_err && s_r.nullify && !s_r.commit;
  endproperty
  a_csum: assert property (p_csum)
    else $error("checksum error not handled");

  property p_lenpar;
    in_comm && !gap_hit && i_fld.valid && i_fld.kind == lkt_pkg::LKT_F_LEN
      && i_fld.par_err
      |=> s_r.flags[3] && in_err && s_r.nullify;
  endproperty
  a_lenpar: assert property (p_lenpar)
    else $error("length parity error not handled");

  property p_hdr;
    s_r.mode == lkt_pkg::LKT_STANDBY && i_fld.valid
      && i_fld.kind == lkt_pkg::LKT_F_HDR && i_fld.hdr_err
      |=> s_r.flags[1] && in_err;
  endproperty
  a_hdr: assert property (p_hdr)
    else $error("header error not handled");

  property p_frame;
    !in_err && !(in_comm && gap_hit) && i_fld.valid && i_fld.stop_err
      |=> s_r.flags[0] && in_err && s_r.nullify;
  endproperty
  a_frame: assert property (p_frame)
    else $error("framing error not handled");

  property p_recover;
    in_err && rec_hit |=> s_r.mode == lkt_pkg::LKT_STANDBY;
  endproperty
  a_recover: assert property (p_recover)
    else $error("no return to standby after idle high");

  property p_stay_err;
    in_err && !i_link && !rec_hit |=> in_err;
  endproperty
  a_stay_err: assert property (p_stay_err)
    else $error("left error mode while line low");

  property p_quiet;
    in_err |=> !s_r.commit && !s_r.rd_go
      && (s_r.flags & ~$past(s_r.flags)) == 7'h00;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("activity while in error mode");
endmodule : lkt_link_err_tracker
`default_nettype wire

// ---- bench/lkt_host_model.sv ----
// Serial master model: framed fields, error reads, idle line
`timescale 1ns/10ps
`default_nettype none
module lkt_host_model (
  input  wire logic           i_mclk,
  output logic                o_link,
  output lkt_pkg::lkt_field_t o_fld,
  output lkt_pkg::lkt_read_t  o_rd
);
  initial begin
    o_link = 1'b1;
    o_fld  = '0;
    o_rd   = '0;
  end

  // Start bit pulls the line low with every field
  task automatic put(input lkt_pkg::lkt_fkind_t k, input logic [7:0] d,
                     input logic [3:0] e, input logic l);
    @(posedge i_mclk);
    o_fld  <= '{1'b1, k, d, e[3], e[2], e[1], e[0], l};
    o_link <= 1'b0;
    @(posedge i_mclk);
    o_fld.valid <= 1'b0;
    o_fld.data  <= ~d;
    o_link      <= 1'b1;
  endtask : put

  // Idle line stays high; stale data scrambled
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      o_link      <= 1'b1;
      o_fld.valid <= 1'b0;
      o_fld.data  <= 8'($urandom);
    end
  endtask : idle

  task automatic rd(input logic [7:0] len);
    @(posedge i_mclk);
    o_rd <= '{1'b1, lkt_pkg::LKT_ERR_ADDR, len};
    @(posedge i_mclk);
    o_rd.valid <= 1'b0;
  endtask : rd
endmodule : lkt_host_model
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the link error tracker
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int FC = 8;
  logic                i_mclk  = 1'b0;
  logic                i_rst_n = 1'b0;
  logic                i_link;
  lkt_pkg::lkt_field_t i_fld;
  lkt_pkg::lkt_read_t  i_rd;
  logic [6:0]          flags;
  lkt_pkg::lkt_mode_t  mode;
  logic                commit;
  logic                nullify;
  logic                rd_go;
  int err_count = 0;
  int checked   = 0;
  int cyc       = 0;
  int n_com     = 0;
  int n_nul     = 0;
  int n_rd      = 0;

  always #2 i_mclk = ~i_mclk;

  lkt_host_model host (
    .i_mclk(i_mclk),
    .o_link(i_link),
    .o_fld (i_fld),
    .o_rd  (i_rd)
  );

  lkt_link_err_tracker #(.FIELD_CYC(FC)) dut (
    .i_mclk     (i_mclk),
    .i_rst_n    (i_rst_n),
    .i_link     (i_link),
    .i_fld      (i_fld),
    .i_rd       (i_rd),
    .o_err_flags(flags),
    .o_mode     (mode),
    .o_commit   (commit),
    .o_nullify  (nullify),
    .o_rd_go    (rd_go)
  );

  // Pulses are counted so a one-cycle output is never missed
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (commit === 1'b1) n_com <= n_com + 1;
    if (nullify === 1'b1) n_nul <= n_nul + 1;
    if (rd_go === 1'b1) n_rd <= n_rd + 1;
    if (cyc == 5000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Clocked updates land before anything is sampled
  task automatic wt(input int n);
    host.idle(n);
    #1;
  endtask : wt

  function automatic logic [7:0] ebit(input int i);
    ebit = 8'h01 << ((i == 4) ? lkt_pkg::LKT_B_CSUM : 3 - i);
  endfunction : ebit

  task automatic head(input logic [7:0] rw, input logic [2:0] e);
    host.put(lkt_pkg::LKT_F_HDR, 8'h55, {2'b0, e[2], 1'b0}, 1'b0);
    host.put(lkt_pkg::LKT_F_RW, rw, {e[1], 3'b0}, 1'b0);
    host.put(lkt_pkg::LKT_F_LEN, 8'h02, {e[0], 3'b0}, 1'b0);
  endtask : head

  task automatic portion(input logic ce, input logic l);
    host.put(lkt_pkg::LKT_F_DATA, 8'($urandom), 4'h0, 1'b0);
    host.put(lkt_pkg::LKT_F_CSUM, 8'($urandom), {3'b0, ce}, l);
  endtask : portion

  initial begin
    logic [7:0] rw;
    int         nn;
    int         nc;
    void'($urandom(54651));
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    wt(1);
    chk({1'b0, flags}, 8'h00);
    chk(8'(mode), 8'(lkt_pkg::LKT_STANDBY));
    head(8'h01, 3'b0);
    portion(1'b0, 1'b0);
    portion(1'b0, 1'b1);
    wt(3);
    chk(8'(n_com), 8'h02);
    // Read with a bad checksum: no write-mode error, read goes ahead
    head(8'h00, 3'b0);
    host.put(lkt_pkg::LKT_F_CSUM, 8'($urandom), 4'h1, 1'b1);
    wt(3);
    chk(8'(n_rd), 8'h01);
    chk({1'b0, flags}, 8'h00);
    chk(8'(n_com), 8'h02);
    chk(8'(mode), 8'(lkt_pkg::LKT_STANDBY));
    // Reserved bits random but never all zero, both directions
    for (int d = 0; d < 2; d++) begin
      rw = 8'((($urandom % 31) + 1) << 1) | 8'(d);
      head(rw, 3'b0);
      wt(2);
      chk({1'b0, flags}, 8'h40);
      chk(8'(mode), 8'(lkt_pkg::LKT_COMM));
      portion(1'b0, 1'b1);
      wt(10);
      chk(8'(n_com), 8'h02);
      chk(8'(n_rd), 8'h01);
      chk({1'b0, flags}, 8'h40);
      host.rd(8'(2 + $urandom % 14));
      wt(2);
      chk({1'b0, flags}, 8'h40);
      host.rd(8'h01);
      wt(2);
      chk({1'b0, flags}, 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      nn = n_nul;
      nc = n_com;
      head(8'h01, (i < 3) ? 3'b001 << i : 3'b000);
      if (i == 3) host.put(lkt_pkg::LKT_F_DATA, 8'h00, 4'h4, 1'b0);
      if (i == 4) begin
        portion(1'b0, 1'b0);
        portion(1'b1, 1'b0);
      end
      wt(2);
      chk({1'b0, flags}, ebit(i));
      chk(8'(mode), 8'(lkt_pkg::LKT_ERROR));
      chk(8'(n_nul != nn), 8'h01);
      chk(8'(n_com - nc), (i == 4) ? 8'h01 : 8'h00);
      // Every error flavour at once while locked out
      host.put(lkt_pkg::LKT_F_HDR, 8'h00, 4'hf, 1'b1);
      wt(28);
      chk({1'b0, flags}, ebit(i));
      chk(8'(mode), 8'(lkt_pkg::LKT_ERROR));
      wt(12);
      chk(8'(mode), 8'(lkt_pkg::LKT_STANDBY));
      chk({1'b0, flags}, ebit(i));
      host.rd(8'h01);
    end
    nn = n_nul;
    head(8'h01, 3'b0);
    portion(1'b0, 1'b0);
    host.put(lkt_pkg::LKT_F_DATA, 8'h3c, 4'h0, 1'b0);
    wt(18);
    chk({1'b0, flags}, 8'h00);
    wt(20);
    chk({1'b0, flags}, 8'h20);
    chk(8'(mode), 8'(lkt_pkg::LKT_STANDBY));
    chk(8'(n_com), 8'h04);
    chk(8'(n_nul - nn), 8'h00);
    host.rd(8'h01);
    wt(2);
    chk({1'b0, flags}, 8'h00);
    conclude();
  end
endmodule : tb
`default_nettype wire
